//--- verilog/pis_pkg.sv
/*
 package of the phy interrupt and special status block: register indices,
 field positions, reset values, clear groups and timing figures.
 assumes one 16-bit management register word per 5-bit register index.
*/
package pis_pkg;
	localparam int unsigned DATA_W = 16;            // management word width
	localparam int unsigned ADDR_W = 5;             // register index width
	localparam int unsigned SPEED_W = 3;            // speed/duplex field width

	// register indices on the management interface
	localparam logic [4:0] REG_FLAGS = 5'h1d;       // interrupt_source_flags
	localparam logic [4:0] REG_MASK = 5'h1e;        // interrupt_mask
	localparam logic [4:0] REG_SPECIAL = 5'h1f;     // phy_special_control_status

	// flag byte layout: bits 7..1 are sources, bit 0 reserved
	localparam logic [7:0] SRC_BITS = 8'hfe;        // implemented flag bits
	localparam logic [7:0] FALL_CLR = 8'hee;        // sources released on falling edge
	localparam logic [7:0] REG1_CLR = 8'h30;        // released by basic status read
	localparam logic [7:0] REG6_CLR = 8'h06;        // released by expansion read, restart, link down
	localparam int unsigned BIT_ENERGY = 7;         // energy event position
	localparam int unsigned BIT_LINK = 4;           // link down position

	// special control/status fields
	localparam int unsigned BIT_AUTODONE = 12;      // auto-negotiation done
	localparam int unsigned BIT_CODER = 6;          // 4b/5b coder enable
	localparam int unsigned BIT_SCRAMBLE = 0;       // scrambler disable
	localparam int unsigned SPEED_LO = 2;           // speed field low bit
	localparam int unsigned SPEED_HI = 4;           // speed field high bit

	// reset values
	localparam logic [7:0] MASK_RST = 8'h00;        // all sources masked
	localparam logic CODER_RST = 1'b1;              // coder enabled
	localparam logic SCRAMBLE_RST = 1'b0;           // scrambling on
	localparam logic ENERGY_RST = 1'b1;             // energy assumed at start

	// timing
	localparam int unsigned CLOCK_MHZ = 100;        // core clock rate
	localparam int unsigned ENERGY_QUIET_MS = 256;  // quiet line interval

	// interrupt release modes
	typedef enum logic {
		PIS_MODE_PRIMARY,
		PIS_MODE_ALTERNATE
	} pis_irq_mode_t;
endpackage

//--- verilog/pis_core.sv
/*
 phy interrupt flags, interrupt mask, special control/status and the
 active-low interrupt output, reached over a parallel register port.
 assumes the serial management framing sits outside and presents one-cycle
 read and write strobes with a register index, all synchronous to clock.
*/
`timescale 1ns/10ps
module pis_core #(
	parameter int unsigned ENERGY_QUIET_CYCLES =
		pis_pkg::ENERGY_QUIET_MS * 1000 * pis_pkg::CLOCK_MHZ
) (
	input  wire logic                        clock,
	input  wire logic                        rst_n,
	input  wire logic [pis_pkg::ADDR_W-1:0]  mgmt_addr,
	input  wire logic                        mgmt_rd,
	input  wire logic                        mgmt_wr,
	input  wire logic [pis_pkg::DATA_W-1:0]  mgmt_wdata,
	output logic      [pis_pkg::DATA_W-1:0]  mgmt_rdata,
	input  wire logic                        alternate_irq_mode_sel,
	input  wire logic                        line_energy_raw,
	input  wire logic                        aneg_complete,
	input  wire logic                        remote_fault,
	input  wire logic                        link_status,
	input  wire logic                        partner_ack,
	input  wire logic                        parallel_detect_fault,
	input  wire logic                        page_received,
	input  wire logic                        basic_status_read,
	input  wire logic                        expansion_read,
	input  wire logic                        aneg_restart,
	input  wire logic                        aneg_done,
	input  wire logic [pis_pkg::SPEED_W-1:0] resolved_speed_duplex,
	output logic                             irq_out_low,
	output logic                             line_energy_present,
	output logic                             coder_enable,
	output logic                             scramble_disable
);
	localparam int unsigned CNT_W = $clog2(ENERGY_QUIET_CYCLES + 1);  // quiet counter width
	localparam logic [CNT_W-1:0] QUIET_LAST = CNT_W'(ENERGY_QUIET_CYCLES - 1);

	pis_pkg::pis_irq_mode_t mode;       // current release mode
	logic [7:0]             src;        // live source levels, bit four inverted link
	logic [7:0]             src_q;      // sources one cycle ago
	logic [7:0]             rise;       // assert events
	logic [7:0]             fall;       // source releases
	logic [7:0]             prim_clr;   // primary mode release vector
	logic [7:0]             alt_clr;    // alternate mode release vector
	logic [7:0]             clr;        // release vector in force
	logic [7:0]             flags;      // latched source flags
	logic [7:0]             next_flags; // flags after this edge
	logic [7:0]             mask;       // source enables
	logic [CNT_W-1:0]       quiet_cnt;  // cycles without line energy
	logic                   rd_flags;   // read strobe on flag register
	logic                   wr_flags;   // write strobe on flag register
	logic                   rd_special; // read strobe on special register

	// register index match, shared by all strobes
	function automatic logic hit(input logic [4:0] a, input logic [4:0] idx);
		hit = (a == idx);
	endfunction

	assign rd_flags = mgmt_rd && hit(mgmt_addr, pis_pkg::REG_FLAGS);
	assign wr_flags = mgmt_wr && hit(mgmt_addr, pis_pkg::REG_FLAGS);
	assign rd_special = mgmt_rd && hit(mgmt_addr, pis_pkg::REG_SPECIAL);

	// mode follows the select input directly; reset does not touch it
	assign mode = alternate_irq_mode_sel ? pis_pkg::PIS_MODE_ALTERNATE
		: pis_pkg::PIS_MODE_PRIMARY;

	// link down is a falling link, so invert it to reuse rising logic
	assign src = {line_energy_present, aneg_complete, remote_fault, ~link_status,
		partner_ack, parallel_detect_fault, page_received, 1'b0};
	assign rise = src & ~src_q & pis_pkg::SRC_BITS;
	assign fall = ~src & src_q;

	// primary release: falling source, related reads, restart, link loss
	always_comb begin
		prim_clr = (fall & pis_pkg::FALL_CLR) | {8{rd_flags}};
		if (basic_status_read) begin
			prim_clr = prim_clr | pis_pkg::REG1_CLR;
		end
		if (expansion_read || aneg_restart || rise[pis_pkg::BIT_LINK]) begin
			prim_clr = prim_clr | pis_pkg::REG6_CLR;
		end
	end

	// alternate release: written one only where the source has gone away
	always_comb begin
		alt_clr = 8'h00;
		if (wr_flags) begin
			alt_clr = mgmt_wdata[7:0] & ~src;
		end
	end

	// both modes assert alike, only the release path differs
	assign clr = (mode == pis_pkg::PIS_MODE_ALTERNATE) ? alt_clr : prim_clr;
	// a new event beats a release in the same cycle
	assign next_flags = ((flags & ~clr) | rise) & pis_pkg::SRC_BITS;

	// source history for edge detection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= 8'h00;  // energy starts high, so its flag sets at once
		end else begin
			src_q <= src;
		end
	end

	// latched flags, bits seven..one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags <= 8'h00;
		end else begin
			flags <= next_flags;
		end
	end

	// mask register, reserved bits stay zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask <= pis_pkg::MASK_RST;
		end else if (mgmt_wr && hit(mgmt_addr, pis_pkg::REG_MASK)) begin
			mask <= mgmt_wdata[7:0] & pis_pkg::SRC_BITS;
		end
	end

	// special control bits; coder bypass is only sane in mii mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			coder_enable <= pis_pkg::CODER_RST;
			scramble_disable <= pis_pkg::SCRAMBLE_RST;
		end else if (mgmt_wr && hit(mgmt_addr, pis_pkg::REG_SPECIAL)) begin
			coder_enable <= mgmt_wdata[pis_pkg::BIT_CODER];
			scramble_disable <= mgmt_wdata[pis_pkg::BIT_SCRAMBLE];
		end
	end

	// energy present until the line has been quiet for the full interval
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			line_energy_present <= pis_pkg::ENERGY_RST;
			quiet_cnt <= '0;
		end else if (line_energy_raw) begin
			line_energy_present <= 1'b1;
			quiet_cnt <= '0;
		end else if (line_energy_present) begin
			if (quiet_cnt == QUIET_LAST) begin
				line_energy_present <= 1'b0;
				quiet_cnt <= '0;
			end else begin
				quiet_cnt <= quiet_cnt + 1'b1;
			end
		end
	end

	// interrupt pin; registered so it never glitches between flag updates
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_out_low <= 1'b1;
		end else begin
			irq_out_low <= ~|(flags & mask);
		end
	end

	// read data, taken the cycle of the strobe; other indices read zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mgmt_rdata <= '0;
		end else if (mgmt_rd) begin
			case (mgmt_addr)
				pis_pkg::REG_FLAGS: begin
					mgmt_rdata <= {8'h00, flags};  // value before any release
				end
				pis_pkg::REG_MASK: begin
					mgmt_rdata <= {8'h00, mask};
				end
				pis_pkg::REG_SPECIAL: begin
					// no release is driven from here
					mgmt_rdata <= '0;
					mgmt_rdata[pis_pkg::BIT_AUTODONE] <= aneg_done;
					mgmt_rdata[pis_pkg::BIT_CODER] <= coder_enable;
					mgmt_rdata[pis_pkg::SPEED_HI:pis_pkg::SPEED_LO] <= resolved_speed_duplex;
					mgmt_rdata[pis_pkg::BIT_SCRAMBLE] <= scramble_disable;
				end
				default: begin
					mgmt_rdata <= '0;
				end
			endcase
		end
	end

	// every assert event shows in its flag one edge later
	property p_flag_set;
		@(posedge clock) disable iff (!rst_n)
		(rise != 8'h00) |=> ((flags & $past(rise)) == $past(rise));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("source event did not latch its flag");

	// mask write lands in the implemented bits only
	property p_mask_write;
		@(posedge clock) disable iff (!rst_n)
		(mgmt_wr && mgmt_addr == pis_pkg::REG_MASK)
			|=> (mask == (pis_pkg::SRC_BITS & 8'($past(mgmt_wdata))));
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask register write mismatch");

	// done bit and speed field reach the read data
	property p_special_read;
		@(posedge clock) disable iff (!rst_n)
		rd_special |=> (mgmt_rdata[pis_pkg::BIT_AUTODONE] == $past(aneg_done))
			&& (mgmt_rdata[pis_pkg::SPEED_HI:pis_pkg::SPEED_LO] == $past(resolved_speed_duplex));
	endproperty
	a_special_read: assert property (p_special_read)
		else $error("special status read data wrong");

	// a special read with nothing else going on leaves flags alone
	property p_special_no_clear;
		@(posedge clock) disable iff (!rst_n)
		(rd_special && !mgmt_wr && rise == 8'h00 && fall == 8'h00 && !basic_status_read
			&& !expansion_read && !aneg_restart) |=> (flags == $past(flags));
	endproperty
	a_special_no_clear: assert property (p_special_no_clear)
		else $error("special status read disturbed flags");

	// control bits follow a special write
	property p_special_write;
		@(posedge clock) disable iff (!rst_n)
		(mgmt_wr && mgmt_addr == pis_pkg::REG_SPECIAL)
			|=> (coder_enable == $past(mgmt_wdata[pis_pkg::BIT_CODER]))
			&& (scramble_disable == $past(mgmt_wdata[pis_pkg::BIT_SCRAMBLE]));
	endproperty
	a_special_write: assert property (p_special_write)
		else $error("special control write mismatch");

	// pin low one edge after an enabled flag, high one after none
	property p_irq_level;
		@(posedge clock) disable iff (!rst_n)
		((flags & mask) != 8'h00) |=> !irq_out_low;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt pin not low for enabled flag");

	property p_irq_idle;
		@(posedge clock) disable iff (!rst_n)
		((flags & mask) == 8'h00) |=> irq_out_low;
	endproperty
	a_irq_idle: assert property (p_irq_idle)
		else $error("interrupt pin low with no enabled flag");

	// primary mode: a flag read with no new event empties the flags
	property p_primary_read;
		@(posedge clock) disable iff (!rst_n)
		(!alternate_irq_mode_sel && rd_flags && rise == 8'h00) |=> (flags == 8'h00);
	endproperty
	a_primary_read: assert property (p_primary_read)
		else $error("primary flag read did not release flags");

	// alternate mode: a flag whose source still stands survives write-one
	property p_alt_hold;
		@(posedge clock) disable iff (!rst_n)
		(alternate_irq_mode_sel && wr_flags)
			|=> ((flags & $past(src) & $past(flags)) == ($past(src) & $past(flags)));
	endproperty
	a_alt_hold: assert property (p_alt_hold)
		else $error("alternate clear dropped a flag with live source");

	// energy drops only at the end of a full quiet count
	property p_energy_quiet;
		@(posedge clock) disable iff (!rst_n)
		$fell(line_energy_present) |-> ($past(quiet_cnt) == QUIET_LAST);
	endproperty
	a_energy_quiet: assert property (p_energy_quiet)
		else $error("energy status dropped early");

	// primary mode: link loss drops both negotiation flags unless they rise again
	property p_link_release;
		@(posedge clock) disable iff (!rst_n)
		(!alternate_irq_mode_sel && rise[pis_pkg::BIT_LINK] && (rise & pis_pkg::REG6_CLR) == 8'h00)
			|=> ((flags & pis_pkg::REG6_CLR) == 8'h00);
	endproperty
	a_link_release: assert property (p_link_release)
		else $error("link loss did not release negotiation flags");
endmodule

//--- bench/pis_mgmt_model.sv
/*
 management controller model: issues one-cycle register reads and writes.
 assumes the block samples strobe, index and data at the rising clock edge.
*/
`timescale 1ns/10ps
module pis_mgmt_model (
	input  wire logic                       clock,
	input  wire logic                       rmii_mode,
	output logic      [pis_pkg::ADDR_W-1:0] mgmt_addr,
	output logic                            mgmt_rd,
	output logic                            mgmt_wr,
	output logic      [pis_pkg::DATA_W-1:0] mgmt_wdata,
	input  wire logic [pis_pkg::DATA_W-1:0] mgmt_rdata
);
	// idle values
	initial begin
		mgmt_addr = 5'h00;
		mgmt_rd = 1'b0;
		mgmt_wr = 1'b0;
		mgmt_wdata = 16'h0000;
	end
	// write cycle; released lines show the inverse so stale values never pass
	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		// coder setting left alone in the reduced interface mode
		if (rmii_mode && a == pis_pkg::REG_SPECIAL) return;
		@(posedge clock);
		#1;
		mgmt_addr = a;
		mgmt_wdata = d;
		mgmt_wr = 1'b1;
		@(posedge clock);
		#1;
		mgmt_wr = 1'b0;
		mgmt_addr = ~a;
		mgmt_wdata = ~d;
	endtask
	// read cycle; data taken one cycle after the strobe edge
	task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clock);
		#1;
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		@(posedge clock);
		#1;
		mgmt_rd = 1'b0;
		mgmt_addr = ~a;
		d = mgmt_rdata;
	endtask
endmodule

//--- bench/phy_interrupt_and_special_status_test.sv
/*
 self-checking bench of the interrupt flags, mask and special register.
 assumes pis_core with a short quiet interval and the controller model.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module phy_interrupt_and_special_status_test;
	logic        clock, rst_n, mode, raw, done_in, rmii, irq, energy, coder, scr, mrd, mwr;
	logic [7:0]  src;                        // bit 4 means link down
	logic [2:0]  rel;                        // basic read, expansion read, restart
	logic [2:0]  speed;                      // resolved speed/duplex
	logic [4:0]  maddr;                      // register index
	logic [15:0] mwdata, mrdata;             // management data
	int          num_errors, num_checks, n;  // counters
	int          relbit[3] = '{5, 1, 2};     // flag released by each pulse
	logic [2:0]  codes[4] = '{3'b001, 3'b101, 3'b010, 3'b110};
	pis_core #(.ENERGY_QUIET_CYCLES(16)) u_dut (.clock(clock), .rst_n(rst_n),
		.mgmt_addr(maddr), .mgmt_rd(mrd), .mgmt_wr(mwr), .mgmt_wdata(mwdata),
		.mgmt_rdata(mrdata), .alternate_irq_mode_sel(mode), .line_energy_raw(raw),
		.aneg_complete(src[6]), .remote_fault(src[5]), .link_status(~src[4]),
		.partner_ack(src[3]), .parallel_detect_fault(src[2]), .page_received(src[1]),
		.basic_status_read(rel[0]), .expansion_read(rel[1]), .aneg_restart(rel[2]),
		.aneg_done(done_in), .resolved_speed_duplex(speed), .irq_out_low(irq),
		.line_energy_present(energy), .coder_enable(coder), .scramble_disable(scr));
	pis_mgmt_model u_mgmt (.clock(clock), .rmii_mode(rmii), .mgmt_addr(maddr),
		.mgmt_rd(mrd), .mgmt_wr(mwr), .mgmt_wdata(mwdata), .mgmt_rdata(mrdata));
	// free running clock
	always #5 clock = ~clock;
	// inputs move 1 ns after the edge
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	// read and compare one register
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string nm);
		logic [15:0] d;
		u_mgmt.reg_rd(a, d);
		`CHK(nm, e, d)
	endtask
	// verdict
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		{clock, rst_n, mode, done_in, rmii, src, rel, num_errors, num_checks} = '0;
		raw = 1'b1;
		speed = 3'b001;
		tick(20);
		rst_n = 1'b1;
		`CHK("irq", 1'b1, irq)
		`CHK("coder", 1'b1, coder)
		`CHK("scramble", 1'b0, scr)
		rd_chk(pis_pkg::REG_MASK, 16'h0000, "mask");
		rd_chk(pis_pkg::REG_FLAGS, 16'h0080, "flags");
		rd_chk(pis_pkg::REG_FLAGS, 16'h0000, "flags");
		// each of the four speed codes, done bit toggling
		for (int i = 0; i < 4; i++) begin
			speed = codes[i];
			done_in = i[0];
			rd_chk(pis_pkg::REG_SPECIAL, {3'b000, done_in, 6'h01, 1'b0, speed, 2'b00},
				"special");
		end
		u_mgmt.reg_wr(pis_pkg::REG_SPECIAL, 16'hffff);
		rd_chk(pis_pkg::REG_SPECIAL, 16'h1059, "special");
		`CHK("scramble", 1'b1, scr)
		u_mgmt.reg_wr(pis_pkg::REG_SPECIAL, 16'h0000);
		rd_chk(pis_pkg::REG_SPECIAL, 16'h1018, "special");
		`CHK("coder", 1'b0, coder)
		u_mgmt.reg_wr(pis_pkg::REG_MASK, 16'hffff);
		rd_chk(pis_pkg::REG_MASK, 16'h00fe, "mask");
		// sources six down to one, each alone, released by a flag read
		for (int b = 6; b > 0; b--) begin
			u_mgmt.reg_wr(pis_pkg::REG_MASK, 16'h0001 << b);
			src[b] = 1'b1;
			tick(4);
			`CHK("irq", 1'b0, irq)
			rd_chk(pis_pkg::REG_FLAGS, 16'h0001 << b, "flags");
			tick(3);
			`CHK("irq", 1'b1, irq)
			src[b] = 1'b0;
			tick(2);
		end
		// release by basic read, expansion read and restart
		for (int k = 0; k < 3; k++) begin
			u_mgmt.reg_wr(pis_pkg::REG_MASK, 16'h0001 << relbit[k]);
			src[relbit[k]] = 1'b1;
			tick(4);
			`CHK("irq", 1'b0, irq)
			rel[k] = 1'b1;
			tick(1);
			rel[k] = 1'b0;
			tick(3);
			`CHK("irq", 1'b1, irq)
			rd_chk(pis_pkg::REG_FLAGS, 16'h0000, "flags");
			src[relbit[k]] = 1'b0;
			tick(2);
		end
		// masked sources latch only; special read clears nothing
		u_mgmt.reg_wr(pis_pkg::REG_MASK, 16'h0000);
		src[3] = 1'b1;
		src[6] = 1'b1;
		tick(4);
		`CHK("irq", 1'b1, irq)
		rd_chk(pis_pkg::REG_SPECIAL, 16'h1018, "special");
		rd_chk(pis_pkg::REG_FLAGS, 16'h0048, "flags");
		src = '0;
		// quiet line drops energy, new energy raises the flag
		u_mgmt.reg_wr(pis_pkg::REG_MASK, 16'h0080);
		raw = 1'b0;
		tick(14);
		`CHK("energy", 1'b1, energy)
		for (n = 0; n < 10 && energy !== 1'b0; n++) tick(1);
		`CHK("energy", 1'b0, energy)
		if (n == 10) begin
			num_errors++;
			stop_test();
		end
		raw = 1'b1;
		tick(4);
		`CHK("irq", 1'b0, irq)
		rd_chk(pis_pkg::REG_FLAGS, 16'h0080, "flags");
		// alternate mode: write-one clears only once the source is low
		mode = 1'b1;
		u_mgmt.reg_wr(pis_pkg::REG_MASK, 16'h0040);
		src[6] = 1'b1;
		tick(4);
		`CHK("irq", 1'b0, irq)
		rd_chk(pis_pkg::REG_FLAGS, 16'h0040, "flags");
		rd_chk(pis_pkg::REG_FLAGS, 16'h0040, "flags");
		u_mgmt.reg_wr(pis_pkg::REG_FLAGS, 16'h0040);
		tick(3);
		`CHK("irq", 1'b0, irq)
		src[6] = 1'b0;
		tick(2);
		u_mgmt.reg_wr(pis_pkg::REG_FLAGS, 16'h0040);
		tick(3);
		`CHK("irq", 1'b1, irq)
		rd_chk(pis_pkg::REG_FLAGS, 16'h0000, "flags");
		// second reset: bench drives the mode select back to primary, reselects later
		rst_n = 1'b0;
		tick(2);
		mode = 1'b0;
		rst_n = 1'b1;
		`CHK("coder", 1'b1, coder)
		rd_chk(pis_pkg::REG_MASK, 16'h0000, "mask");
		rd_chk(pis_pkg::REG_FLAGS, 16'h0080, "flags");
		rd_chk(pis_pkg::REG_FLAGS, 16'h0000, "flags");
		// link loss releases the two negotiation flags, the read clears the rest
		src[2] = 1'b1;
		src[1] = 1'b1;
		tick(2);
		src[4] = 1'b1;
		tick(3);
		rd_chk(pis_pkg::REG_FLAGS, 16'h0010, "flags");
		src = '0;
		tick(2);
		// reselected alternate mode: reads keep the flag, the mask gates the pin
		mode = 1'b1;
		src[5] = 1'b1;
		tick(2);
		rd_chk(pis_pkg::REG_FLAGS, 16'h0020, "flags");
		u_mgmt.reg_wr(pis_pkg::REG_MASK, 16'h0020);
		tick(2);
		`CHK("irq", 1'b0, irq)
		u_mgmt.reg_wr(pis_pkg::REG_MASK, 16'h0000);
		tick(2);
		`CHK("irq", 1'b1, irq)
		rd_chk(pis_pkg::REG_FLAGS, 16'h0020, "flags");
		src[5] = 1'b0;
		tick(2);
		u_mgmt.reg_wr(pis_pkg::REG_FLAGS, 16'h0020);
		rd_chk(pis_pkg::REG_FLAGS, 16'h0000, "flags");
		mode = 1'b0;
		// reduced interface mode: the controller leaves the coder setting alone
		rmii = 1'b1;
		u_mgmt.reg_wr(pis_pkg::REG_SPECIAL, 16'h0000);
		`CHK("coder", 1'b1, coder)
		rmii = 1'b0;
		stop_test();
	end
endmodule
